// ---- cen_pkg.sv ----
// Purpose: shared constants for the camera event notifier
// Assumes: register port with one-cycle read latency
// Notes:   all offsets are word indices on the plain register port
`default_nettype none
package cen_pkg;
  // Event codes, also the index into the enable bits
  localparam logic [3:0] EV_FRAME_BEGIN    = 4'h0;
  localparam logic [3:0] EV_EXPOSURE_BEGIN = 4'h1;
  localparam logic [3:0] EV_EXPOSURE_END   = 4'h2;
  localparam logic [3:0] EV_ACQ_REARM      = 4'h3;
  localparam logic [3:0] EV_TRIG_ACCEPT    = 4'h4;
  localparam logic [3:0] EV_TRIG_REJECT    = 4'h5;
  localparam logic [3:0] EV_IMAGE_DROP     = 4'h6;
  localparam logic [3:0] EV_COUNTER_DONE   = 4'h7;
  localparam logic [3:0] EV_IN_A_RISE      = 4'h8;
  localparam logic [3:0] EV_IN_A_FALL      = 4'h9;
  localparam logic [3:0] EV_IN_B_RISE      = 4'ha;
  localparam logic [3:0] EV_IN_B_FALL      = 4'hb;
  localparam logic [3:0] EV_OVERFLOW       = 4'hc;
  localparam int         NUM_EVENTS        = 13;
  localparam int         NUM_SOURCES       = 12;

  // Register offsets
  localparam logic [3:0] REG_NOTIFY_SELECT = 4'h0;
  localparam logic [3:0] REG_NOTIFY_ENABLE = 4'h1;
  localparam logic [3:0] REG_STAT_SELECT   = 4'h2;
  localparam logic [3:0] REG_STAT_VALUE    = 4'h3;
  localparam logic [3:0] REG_STAT_CLEAR    = 4'h4;
  localparam logic [3:0] REG_TIME_SYNC     = 4'h5;
  localparam logic [3:0] REG_STATUS        = 4'h6;
  localparam logic [3:0] REG_COUNTER_TGT   = 4'h7;

  // Notify enable values
  localparam logic [1:0] NOTIFY_OFF    = 2'h0;
  localparam logic [1:0] NOTIFY_ON     = 2'h1;
  localparam logic [1:0] NOTIFY_LEGACY = 2'h2;

  // Statistic selector values
  localparam logic [2:0] STAT_TRIG_REJECT  = 3'h0;
  localparam logic [2:0] STAT_IMAGE_DROP   = 3'h1;
  localparam logic [2:0] STAT_RESENT_PKT   = 3'h2;
  localparam logic [2:0] STAT_DROPPED_REQ  = 3'h3;
  localparam logic [2:0] STAT_PAUSE_FRAME  = 3'h4;
  localparam int         NUM_STATS         = 5;

  // Time-sync setting values
  localparam logic [1:0] SYNC_OFF   = 2'h0;
  localparam logic [1:0] SYNC_AUTO  = 2'h1;
  localparam logic [1:0] SYNC_SLAVE = 2'h2;

  // Status bit positions
  localparam int ST_OVERFLOW_BIT = 0;
  localparam int ST_TS_SRC_BIT   = 1;
  localparam int ST_MASTER_BIT   = 2;
  localparam int ST_SLAVE_BIT    = 3;

  localparam logic [31:0] COUNTER_TGT_RESET = 32'h0000_0000;
endpackage : cen_pkg
`default_nettype wire

// ---- cen_notifier.sv ----
// Purpose: event notification, statistics and time-sync mode control
// Assumes: event inputs are single-cycle pulses from on-chip logic, except input lines
// Notes:   one message per cycle leaves through a small FIFO toward the control channel
//
// How it works
// - Frame begin, at exposure delay start, sends a frame-begin message.
// - Exposure start and exposure end each send their own message.
// - Acquisition command becoming usable again sends a rearm message.
// - Every valid frame trigger sends a trigger-accepted message.
// - Trigger while not allowed is rejected, no frame starts, message sent.
// - Image discarded for lack of memory sends an image-dropped message.
// - Counter one reaching its target count sends a counter-done message.
// - Rise and fall on input lines a and b give four messages.
// - Queue overflow disables all events except overflow and sends one overflow message.
// - Per-event enable chosen by selector; off suppresses, on notifies.
// - Legacy enable value behaves exactly like on.
// - Selector picks a statistic; value reads it; clear resets only it.
// - Rejected trigger statistic counts each disallowed trigger.
// - Image-dropped statistic counts images discarded before transfer end.
// - Resent-packet statistic counts each packet sent again.
// - Resend requests queue boundedly; full queue drops request, still counts.
// - Pause-frame statistic counts each received pause frame.
// - Sync off takes no part; automatic role from the selection algorithm.
// - Slave-only setting never takes the master role.
// - Time sync enabled switches timestamp source to the network clock.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`default_nettype none
module cen_notifier
  import cen_pkg::*;
#(
  parameter int FIFO_DEPTH   = 4,
  parameter int RESEND_DEPTH = 4,
  parameter int STAT_W       = 32
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        frame_begin,
  input  wire logic        exposure_begin,
  input  wire logic        exposure_finish,
  input  wire logic        acquisition_rearm,
  input  wire logic        frame_trigger,
  input  wire logic        trigger_allowed,
  input  wire logic        image_dropped,
  input  wire logic        counter_tick,
  input  wire logic        input_a_pin,
  input  wire logic        input_b_pin,
  input  wire logic        packet_resent,
  input  wire logic        resend_request,
  input  wire logic        resend_taken,
  input  wire logic        pause_frame,
  input  wire logic        bmc_master_wins,
  input  wire logic        msg_ready,
  output logic             msg_valid,
  output logic      [3:0]  msg_code,
  output logic             trigger_start,
  output logic             resend_pending,
  output logic             sync_active,
  output logic             ts_src_network,
  output logic             role_master,
  output logic             role_slave
);
  localparam int FAW = $clog2(FIFO_DEPTH);
  localparam int RAW = $clog2(RESEND_DEPTH + 1);

  // Input line synchronisers and edge history
  logic [1:0] in_s1_q, in_s2_q, in_d_q;
  always_ff @(posedge clock)
  begin
    in_s1_q <= {input_b_pin, input_a_pin};
    in_s2_q <= in_s1_q;
    in_d_q  <= in_s2_q;
  end
  wire [1:0] rise = in_s2_q & ~in_d_q;
  wire [1:0] fall = ~in_s2_q & in_d_q;

  // Counter one
  logic [31:0] cnt_tgt_q, cnt_q;
  wire cnt_hit = counter_tick && (cnt_q + 32'h1 == cnt_tgt_q);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_q <= 32'h0;
    else if (cnt_hit)
      cnt_q <= 32'h0;
    else if (counter_tick)
      cnt_q <= cnt_q + 32'h1;
  end

  wire trig_ok  = frame_trigger && trigger_allowed;
  wire trig_bad = frame_trigger && !trigger_allowed;

  // Rejected triggers never start a frame
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      trigger_start <= 1'b0;
    else
      trigger_start <= trig_ok;
  end

  // Raw event sources, one bit per code below overflow
  wire [NUM_SOURCES-1:0] src = {
    fall[1], rise[1], fall[0], rise[0],
    cnt_hit,
    image_dropped,
    trig_bad,
    trig_ok,
    acquisition_rearm,
    exposure_finish, exposure_begin,
    frame_begin
  };

  // Enables and selection
  logic [NUM_EVENTS-1:0] en_q;
  logic [3:0]            sel_q;
  logic [2:0]            stat_sel_q;
  logic [1:0]            sync_q;
  logic                  ovf_flag_q;
  logic                  ovf_pend_q;

  wire wr_sel  = reg_wr && reg_addr == REG_NOTIFY_SELECT;
  wire wr_en   = reg_wr && reg_addr == REG_NOTIFY_ENABLE;
  wire wr_ssel = reg_wr && reg_addr == REG_STAT_SELECT;
  wire wr_clr  = reg_wr && reg_addr == REG_STAT_CLEAR;
  wire wr_sync = reg_wr && reg_addr == REG_TIME_SYNC;
  wire wr_tgt  = reg_wr && reg_addr == REG_COUNTER_TGT;
  wire wr_st   = reg_wr && reg_addr == REG_STATUS;
  wire en_val  = reg_wdata[1:0] == NOTIFY_ON
              || reg_wdata[1:0] == NOTIFY_LEGACY;

  // Gated events and FIFO push
  wire [NUM_SOURCES-1:0] gated = src & en_q[NUM_SOURCES-1:0];
  logic [3:0] push_code;
  always_comb
  begin
    push_code = 4'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--)
      if (gated[i])
        push_code = 4'(i);
  end

  logic [3:0] fifo_q [FIFO_DEPTH];
  logic [FAW:0] wp_q, rp_q;
  wire [FAW:0] used   = wp_q - rp_q;
  wire fifo_full      = used == (FAW+1)'(FIFO_DEPTH);
  wire pop            = msg_valid && msg_ready;
  wire any_ev         = |gated;
  // Extra events in one cycle or an event into a full queue count as overflow
  wire multi_ev       = |(gated & (gated - 12'h1));
  wire overflow       = any_ev && (fifo_full || multi_ev);
  wire push_ev        = any_ev && !fifo_full;
  wire push_ovf       = !push_ev && ovf_pend_q && !fifo_full && en_q[EV_OVERFLOW];
  wire push           = push_ev || push_ovf;
  wire [3:0] push_val = push_ev ? push_code : EV_OVERFLOW;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge clock)
  begin
    if (push)
      fifo_q[wp_q[FAW-1:0]] <= push_val;
  end

  // Output stage
  wire [FAW:0] rp_n = pop ? rp_q + 1'b1 : rp_q;
  wire next_valid   = (wp_q != rp_n);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      msg_valid <= 1'b0;
      msg_code  <= 4'h0;
    end
    else if (!msg_valid || pop)
    begin
      msg_valid <= next_valid;
      if (next_valid)
        msg_code <= fifo_q[rp_n[FAW-1:0]];
    end
  end

  // Enable bits, selectors and overflow state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      en_q       <= '0;
      sel_q      <= 4'h0;
      stat_sel_q <= 3'h0;
      sync_q     <= SYNC_OFF;
      cnt_tgt_q  <= COUNTER_TGT_RESET;
      ovf_flag_q <= 1'b0;
      ovf_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_sel)
        sel_q <= reg_wdata[3:0];
      if (wr_ssel)
        stat_sel_q <= reg_wdata[2:0];
      if (wr_sync)
        sync_q <= reg_wdata[1:0];
      if (wr_tgt)
        cnt_tgt_q <= reg_wdata;
      if (overflow)
      begin
        en_q[NUM_SOURCES-1:0] <= '0;
        ovf_pend_q            <= 1'b1;
      end
      else
      begin
        if (wr_en && sel_q < 4'(NUM_EVENTS))
          en_q[sel_q] <= en_val;
        if (push_ovf || !en_q[EV_OVERFLOW])
          ovf_pend_q <= 1'b0;
      end
      // Set wins over the software clear
      if (overflow)
        ovf_flag_q <= 1'b1;
      else if (wr_st && reg_wdata[ST_OVERFLOW_BIT])
        ovf_flag_q <= 1'b0;
    end
  end

  // Resend request queue occupancy
  logic [RAW-1:0] rq_cnt_q;
  wire rq_full = rq_cnt_q == RAW'(RESEND_DEPTH);
  wire rq_in   = resend_request && !rq_full;
  wire rq_out  = resend_taken && rq_cnt_q != '0;
  wire rq_drop = resend_request && rq_full && !rq_out;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rq_cnt_q <= '0;
    else if (rq_in && !rq_out)
      rq_cnt_q <= rq_cnt_q + 1'b1;
    else if (rq_out && !(resend_request && (!rq_full || rq_out)))
      rq_cnt_q <= rq_cnt_q - 1'b1;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      resend_pending <= 1'b0;
    else
      resend_pending <= (rq_cnt_q != '0) || resend_request;
  end

  // Statistic counters
  wire [NUM_STATS-1:0] stat_inc = {
    pause_frame,
    rq_drop,
    packet_resent,
    image_dropped,
    trig_bad
  };
  logic [STAT_W-1:0] stat_q [NUM_STATS];
  for (genvar g = 0; g < NUM_STATS; g++)
  begin : g_stat
    wire clr = wr_clr && stat_sel_q == 3'(g);
    always_ff @(posedge clock)
    begin
      if (!rst_n)
        stat_q[g] <= '0;
      else if (stat_inc[g])
        stat_q[g] <= clr ? STAT_W'(1) : stat_q[g] + 1'b1;
      else if (clr)
        stat_q[g] <= '0;
    end
  end
  wire [STAT_W-1:0] stat_rd = stat_sel_q < 3'(NUM_STATS) ? stat_q[stat_sel_q] : '0;

  // Time-sync role
  wire sync_on = sync_q == SYNC_AUTO || sync_q == SYNC_SLAVE;
  wire master_d = sync_q == SYNC_AUTO && bmc_master_wins;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync_active    <= 1'b0;
      ts_src_network <= 1'b0;
      role_master    <= 1'b0;
      role_slave     <= 1'b0;
    end
    else
    begin
      sync_active    <= sync_on;
      ts_src_network <= sync_on;
      role_master    <= master_d;
      role_slave     <= sync_on && !master_d;
    end
  end

  // Read port
  wire [31:0] status_w = {28'h0, role_slave, role_master, ts_src_network, ovf_flag_q};
  wire [31:0] en_rd    = sel_q < 4'(NUM_EVENTS) ? {31'h0, en_q[sel_q]} : 32'h0;
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      REG_NOTIFY_SELECT: rd_mux = {28'h0, sel_q};
      REG_NOTIFY_ENABLE: rd_mux = en_rd;
      REG_STAT_SELECT:   rd_mux = {29'h0, stat_sel_q};
      REG_STAT_VALUE:    rd_mux = 32'(stat_rd);
      REG_TIME_SYNC:     rd_mux = {30'h0, sync_q};
      REG_STATUS:        rd_mux = status_w;
      REG_COUNTER_TGT:   rd_mux = cnt_tgt_q;
      default:           rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // Checks
  ovf_disables_a: assert property (@(posedge clock) disable iff (!rst_n)
    overflow |=> en_q[NUM_SOURCES-1:0] == '0)
    else $error("overflow left events enabled");
  reject_nostart_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig_bad |=> !trigger_start)
    else $error("rejected trigger started a frame");
  reject_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig_bad && !wr_clr |=> stat_q[0] == $past(stat_q[0]) + 1'b1)
    else $error("rejected trigger not counted");
  drop_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    rq_drop && !wr_clr |=> stat_q[3] == $past(stat_q[3]) + 1'b1)
    else $error("dropped request not counted");
  slave_never_master_a: assert property (@(posedge clock) disable iff (!rst_n)
    sync_q == SYNC_SLAVE ##1 sync_q == SYNC_SLAVE |-> !role_master)
    else $error("slave-only became master");
  ts_source_a: assert property (@(posedge clock) disable iff (!rst_n)
    sync_on |=> ts_src_network)
    else $error("timestamp source not switched");
  fifo_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    used <= (FAW+1)'(FIFO_DEPTH))
    else $error("message queue overrun");
  legacy_on_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en && !overflow && reg_wdata[1:0] == NOTIFY_LEGACY && sel_q < 4'(NUM_EVENTS)
    |=> en_q[$past(sel_q)])
    else $error("legacy value did not enable");
  // Message held while the channel stalls
  sequence msg_stalled_s;
    msg_valid && !msg_ready;
  endsequence
  msg_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    msg_stalled_s |=> msg_valid && $stable(msg_code))
    else $error("message lost while stalled");
  // Clear of the rejected-trigger statistic when it is selected
  stat_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_clr && stat_sel_q == STAT_TRIG_REJECT && !trig_bad |=> stat_q[0] == '0)
    else $error("statistic not cleared");
endmodule : cen_notifier
`default_nettype wire

// ---- cen_host_model.sv ----
// Purpose: control channel host that takes event messages
// Assumes: valid/ready stream, one message taken per ready cycle
// Notes:   ready stalls two cycles of four so the queue must hold
`default_nettype none
module cen_host_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       msg_valid,
  input  wire logic [3:0] msg_code,
  output var  logic       msg_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stall_q;
  logic [3:0] got_q[$];
  assign msg_ready = stall_q[1];
  always @(posedge clock)
  begin
    if (!rst_n)
      stall_q <= 2'h0;
    else
    begin
      stall_q <= stall_q + 2'h1;
      if (msg_valid && msg_ready)
        got_q.push_back(msg_code);
    end
  end
endmodule : cen_host_model
`default_nettype wire

// ---- camera_event_notifier_tb.sv ----
// Purpose: self-checking bench for the event notifier
// Assumes: host model takes messages with stalls
// Notes:   expected messages kept in a bench queue, expected counts in bench variables
`default_nettype none
module camera_event_notifier_tb
  import cen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [10:0] ev = 11'h0;
  logic        trig_ok = 1'b0;
  logic        pin_a = 1'b0;
  logic        pin_b = 1'b0;
  logic        bmc = 1'b0;
  logic        msg_valid, msg_ready, trigger_start, resend_pending;
  logic        sync_active, ts_src_network, role_master, role_slave;
  logic [3:0]  msg_code;
  logic [3:0]  exp_q[$];
  logic [15:0] lfsr = 16'hf1c5;
  logic [31:0] rv;
  logic [1:0]  md;
  logic        act, mas;
  int          errors = 0;
  int          num_checks = 0;
  int          starts = 0;
  int          n;
  localparam int RESEND_DEPTH_TB = 4;

  cen_notifier cen_notifier_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_begin(ev[0]), .exposure_begin(ev[1]), .exposure_finish(ev[2]),
    .acquisition_rearm(ev[3]), .frame_trigger(ev[4]), .trigger_allowed(trig_ok),
    .image_dropped(ev[5]), .counter_tick(ev[6]), .input_a_pin(pin_a), .input_b_pin(pin_b),
    .packet_resent(ev[7]), .resend_request(ev[8]), .resend_taken(ev[9]),
    .pause_frame(ev[10]), .bmc_master_wins(bmc), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_code(msg_code), .trigger_start(trigger_start),
    .resend_pending(resend_pending), .sync_active(sync_active),
    .ts_src_network(ts_src_network), .role_master(role_master), .role_slave(role_slave));
  cen_host_model cen_host_model_inst (.clock(clock), .rst_n(rst_n), .msg_valid(msg_valid),
    .msg_code(msg_code), .msg_ready(msg_ready));

  always #2.5 clock = ~clock;
  always @(posedge clock)
    if (trigger_start === 1'b1)
      starts <= starts + 1;

  function automatic logic [15:0] lfsr_next(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic pulse(input int i, input int cnt);
    repeat (cnt)
    begin
      @(posedge clock);
      ev[i] <= 1'b1;
      @(posedge clock);
      ev[i] <= 1'b0;
    end
    repeat (12) @(posedge clock);
  endtask : pulse

  task automatic enable(input int e, input logic [1:0] v);
    wr(REG_NOTIFY_SELECT, 32'(e));
    wr(REG_NOTIFY_ENABLE, {30'h0, v});
  endtask : enable

  task automatic stat(input logic [2:0] sel, input int expv);
    wr(REG_STAT_SELECT, {29'h0, sel});
    rd(REG_STAT_VALUE, rv);
    check(rv, 32'(expv));
  endtask : stat

  task automatic drain(input string name);
    for (int w = 0; w < 80 && cen_host_model_inst.got_q.size() < exp_q.size(); w++)
      @(posedge clock);
    repeat (10) @(posedge clock);
    check(cen_host_model_inst.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && cen_host_model_inst.got_q.size() > 0)
      check(cen_host_model_inst.got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    cen_host_model_inst.got_q.delete();
    $display("test %s done", name);
  endtask : drain

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #100000;
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_STATUS, rv);
    check(rv, 32'h0);
    rd(REG_NOTIFY_ENABLE, rv);
    check(rv, 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, rv);
    check(rv, 32'h0);
    stat(STAT_TRIG_REJECT, 0);
    for (int e = 0; e < NUM_EVENTS; e++)
      enable(e, (e % 2 == 1) ? NOTIFY_LEGACY : NOTIFY_ON);
    wr(REG_NOTIFY_SELECT, 32'h1);
    rd(REG_NOTIFY_ENABLE, rv);
    check(rv[0], 32'h1);
    wr(REG_COUNTER_TGT, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      pulse(i, 1);
      exp_q.push_back(i[3:0]);
    end
    trig_ok <= 1'b1;
    pulse(4, 1);
    exp_q.push_back(EV_TRIG_ACCEPT);
    trig_ok <= 1'b0;
    pulse(4, 1);
    exp_q.push_back(EV_TRIG_REJECT);
    pulse(5, 1);
    exp_q.push_back(EV_IMAGE_DROP);
    pulse(6, 3);
    exp_q.push_back(EV_COUNTER_DONE);
    pin_a <= 1'b1;
    pulse(0, 0);
    pin_a <= 1'b0;
    pulse(0, 0);
    pin_b <= 1'b1;
    pulse(0, 0);
    pin_b <= 1'b0;
    pulse(0, 0);
    for (int i = 8; i < 12; i++)
      exp_q.push_back(i[3:0]);
    enable(0, NOTIFY_OFF);
    pulse(0, 1);
    drain("events");
    check(32'(starts), 32'h1);
    stat(STAT_TRIG_REJECT, 1);
    stat(STAT_IMAGE_DROP, 1);
    lfsr = lfsr_next(lfsr);
    n = int'(lfsr[2:0]) + 1;
    pulse(7, n);
    stat(STAT_RESENT_PKT, n);
    pulse(8, RESEND_DEPTH_TB + 1);
    stat(STAT_DROPPED_REQ, 1);
    check(resend_pending, 32'h1);
    pulse(9, RESEND_DEPTH_TB);
    check(resend_pending, 32'h0);
    lfsr = lfsr_next(lfsr);
    n = int'(lfsr[2:0]) + 1;
    pulse(10, n);
    stat(STAT_PAUSE_FRAME, n);
    wr(REG_STAT_SELECT, {29'h0, STAT_TRIG_REJECT});
    wr(REG_STAT_CLEAR, 32'h0);
    stat(STAT_TRIG_REJECT, 0);
    stat(STAT_IMAGE_DROP, 1);
    $display("test stats done");
    enable(0, NOTIFY_ON);
    @(posedge clock);
    ev[1:0] <= 2'h3;
    @(posedge clock);
    ev[1:0] <= 2'h0;
    exp_q.push_back(EV_FRAME_BEGIN);
    exp_q.push_back(EV_OVERFLOW);
    drain("overflow");
    wr(REG_NOTIFY_SELECT, 32'h1);
    rd(REG_NOTIFY_ENABLE, rv);
    check(rv, 32'h0);
    rd(REG_STATUS, rv);
    check(rv[ST_OVERFLOW_BIT], 32'h1);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, rv);
    check(rv[ST_OVERFLOW_BIT], 32'h0);
    pulse(1, 1);
    drain("disabled");
    enable(1, NOTIFY_ON);
    pulse(1, 1);
    exp_q.push_back(EV_EXPOSURE_BEGIN);
    drain("reenable");
    for (int i = 0; i < 4; i++)
    begin
      md = (i == 0) ? SYNC_OFF : ((i == 3) ? SYNC_SLAVE : SYNC_AUTO);
      bmc <= (i != 2);
      wr(REG_TIME_SYNC, {30'h0, md});
      repeat (4) @(posedge clock);
      act = (md != SYNC_OFF);
      mas = (md == SYNC_AUTO) && (i != 2);
      check({role_slave, role_master, ts_src_network, sync_active},
            {act && !mas, mas, act, act});
      rd(REG_STATUS, rv);
      check(rv[3:1], {act && !mas, mas, act});
    end
    $display("test sync done");
    end_sim();
  end
endmodule : camera_event_notifier_tb
`default_nettype wire
